//--- bench/camera_model.sv
// Behavioural camera driving the lanes, line and frame valid and pixel clock
`default_nettype none
module camera_model
	import tap_pkg::*;
(
	output var lanes_type lane_o,
	output var logic      line_valid_o,
	output var logic      frame_valid_o,
	output var logic      pixel_clock_o
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		lane_o = '0;
		line_valid_o = 1'b0;
		frame_valid_o = 1'b0;
		pixel_clock_o = 1'b0;
	end
	task automatic set_line(input logic v);
		#40 line_valid_o = v;
		#40;
	endtask
	task automatic frame_start();
		#3 frame_valid_o = 1'b1;
		set_line(1'b1);
	endtask
	task automatic frame_end();
		set_line(1'b0);
		frame_valid_o = 1'b0;
		// Released lanes show the inverse so a stale value never passes
		lane_o = ~lane_o;
		#80;
	endtask
	// Lanes settle 20 ns before the rise and hold 60 ns after it
	task automatic send(input tap_mode_type m, input logic [MAX_TAPS-1:0][TAP_BITS-1:0] t);
		lanes_type l;
		l = '0;
		l[LANE_K] = 8'ha5;
		if (m == ten_tap_8bit) begin
			for (int n = 0; n < MAX_TAPS; n++) l[n] = t[n][7:0];
		end else begin
			l[9] = 8'h5a;
			for (int n = 0; n < EIGHT_TAP_COUNT; n++) begin
				l[n] = t[n][9:2];
				if (n < 4) l[LANE_I][2*n+:2] = t[n][1:0];
				else l[LANE_K][2*(n-4)+:2] = t[n][1:0];
			end
		end
		lane_o = l;
		#20 pixel_clock_o = 1'b1;
		#40 pixel_clock_o = 1'b0;
		#20;
	endtask
endmodule // camera_model
`default_nettype wire

//--- bench/tap_unpack_output_lut_bench.sv
// Self-checking bench for the tap unpacker and output table
`default_nettype none
`define CHECK(nm, ex, got) begin n_compared++; if ((got) !== (ex)) begin n_fail++; \
	$display("unexpected %s exp %h got %h", nm, ex, got); end end
module tap_unpack_output_lut_bench
	import tap_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic                   clock_i;
	logic                   rst_i;
	lanes_type              lane;
	logic                   line_valid;
	logic                   frame_valid;
	logic                   pixel_clock;
	config_type             cfg;
	logic                   table_write;
	logic [LUT_IN_BITS-1:0] table_addr;
	logic [PIX_BITS-1:0]    table_data;
	logic                   out_ready;
	logic                   out_valid;
	word_type               out_data;
	logic                   out_last;
	logic                   frame_active;
	logic                   overflow;
	logic                   config_error;
	int                     n_fail;
	int                     n_compared;
	config_type             cases[11];

	camera_model cam_u (.lane_o(lane), .line_valid_o(line_valid), .frame_valid_o(frame_valid),
		.pixel_clock_o(pixel_clock));
	tap_unpack_output_lut dut_u (.clock_i(clock_i), .rst_i(rst_i), .lane_i(lane),
		.line_valid_i(line_valid), .frame_valid_i(frame_valid), .pixel_clock_i(pixel_clock),
		.tap_mode_i(cfg.mode), .depth_i(cfg.depth), .format_i(cfg.format), .lut_enable_i(cfg.lut_on),
		.table_write_i(table_write), .table_addr_i(table_addr), .table_data_i(table_data),
		.out_ready_i(out_ready), .out_valid_o(out_valid), .out_data_o(out_data), .out_last_o(out_last),
		.frame_active_o(frame_active), .overflow_o(overflow), .config_error_o(config_error));

	initial begin
		clock_i = 1'b0;
		forever #5 clock_i = ~clock_i;
	end

	task automatic print_verdict();
		$display("compared %0d mismatches %0d", n_compared, n_fail);
		if (n_fail == 0 && n_compared > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask

	function automatic logic [MAX_TAPS-1:0][TAP_BITS-1:0] taps_of(input int g);
		logic [MAX_TAPS-1:0][TAP_BITS-1:0] t;
		for (int n = 0; n < MAX_TAPS; n++) t[n] = TAP_BITS'(g * 37 + n * 83 + 5);
		return t;
	endfunction
	function automatic logic [PIX_BITS-1:0] tbl(input logic [TAP_BITS-1:0] a);
		return PIX_BITS'((a * 7) ^ 16'hc35a);
	endfunction
	function automatic logic [PIX_BITS-1:0] expect_pix(input logic [TAP_BITS-1:0] tap);
		logic [TAP_BITS-1:0] s;
		int w;
		s = (cfg.mode == ten_tap_8bit) ? {2'h0, tap[7:0]} : tap;
		w = (cfg.depth == depth_8) ? 8 : (cfg.depth == depth_10) ? 10 : 12;
		if (!cfg.lut_on) return PIX_BITS'(s) & PIX_BITS'((32'h1 << w) - 1);
		if (cfg.format inside {gray_byte, color_byte_per_channel}) w = 8;
		else if (cfg.format == color_ten_bit_per_channel) w = 10;
		return tbl(s) & PIX_BITS'((32'h1 << w) - 1);
	endfunction

	task automatic set_cfg(input config_type c);
		@(posedge clock_i);
		cfg <= c;
		repeat (8) @(posedge clock_i);
	endtask
	task automatic send_frame(input int g0, input int ng);
		cam_u.frame_start();
		for (int g = g0; g < g0 + ng; g++) cam_u.send(cfg.mode, taps_of(g));
		cam_u.frame_end();
	endtask
	// Sink stays ready for the whole burst, so words are judged at the falling edge before the take
	task automatic collect(input int g0, input int ng);
		logic [MAX_TAPS-1:0][TAP_BITS-1:0] t;
		int nt;
		int k;
		nt = (cfg.mode == eight_tap_10bit) ? EIGHT_TAP_COUNT : MAX_TAPS;
		@(posedge clock_i);
		out_ready <= 1'b1;
		for (int g = g0; g < g0 + ng; g++) begin
			t = taps_of(g);
			for (int p = 0; p < nt; p += 2) begin
				k = 0;
				@(negedge clock_i);
				while (out_valid !== 1'b1 && k < 300) begin
					@(negedge clock_i);
					k++;
				end
				if (k >= 300) begin
					n_fail++;
					print_verdict();
				end
				`CHECK("first", expect_pix(t[p]), out_data.first)
				`CHECK("second", expect_pix(t[p+1]), out_data.second)
				`CHECK("last", (p == nt - 2), out_last)
				@(posedge clock_i);
			end
		end
		out_ready <= 1'b0;
	endtask
	task automatic expect_idle(input int n, output logic seen);
		seen = 1'b0;
		@(posedge clock_i);
		out_ready <= 1'b1;
		repeat (n) @(negedge clock_i) if (out_valid !== 1'b0) seen = 1'b1;
		@(posedge clock_i);
		out_ready <= 1'b0;
	endtask

	task automatic test_reset();
		`CHECK("valid", 1'b0, out_valid)
		`CHECK("overflow", 1'b0, overflow)
		`CHECK("cfg_err", 1'b0, config_error)
		$display("end of reset test");
	endtask
	task automatic test_bypass();
		set_cfg('{ten_tap_8bit, depth_8, gray_byte, 1'b0});
		cam_u.frame_start();
		`CHECK("frame", 1'b1, frame_active)
		cam_u.send(cfg.mode, taps_of(0));
		cam_u.send(cfg.mode, taps_of(1));
		cam_u.frame_end();
		collect(0, 2);
		set_cfg('{eight_tap_10bit, depth_10, gray_halfword, 1'b0});
		send_frame(2, 2);
		collect(2, 2);
		$display("end of bypass test");
	endtask
	task automatic test_table();
		logic [MAX_TAPS-1:0][TAP_BITS-1:0] t;
		@(posedge clock_i);
		table_write <= 1'b1;
		for (int g = 20; g < 31; g++) begin
			t = taps_of(g);
			for (int n = 0; n < MAX_TAPS; n++) for (int h = 0; h < 2; h++) begin
				table_addr <= LUT_IN_BITS'(h ? {2'h0, t[n][7:0]} : t[n]);
				table_data <= tbl(h ? {2'h0, t[n][7:0]} : t[n]);
				@(posedge clock_i);
			end
		end
		table_write <= 1'b0;
		for (int i = 0; i < 11; i++) begin
			set_cfg(cases[i]);
			send_frame(20 + i, 1);
			collect(20 + i, 1);
		end
		$display("end of table test");
	endtask
	task automatic test_illegal();
		logic seen;
		for (int i = 0; i < 2; i++) begin
			set_cfg('{ten_tap_8bit, depth_8, i ? color_halfword_per_channel : color_ten_bit_per_channel, 1'b1});
			`CHECK("cfg_err", 1'b1, config_error)
			send_frame(5, 1);
			expect_idle(40, seen);
			`CHECK("dropped", 1'b0, seen)
		end
		set_cfg('{ten_tap_8bit, depth_8, gray_byte, 1'b1});
		`CHECK("cfg_err", 1'b0, config_error)
		cam_u.frame_start();
		cam_u.set_line(1'b0);
		cam_u.send(cfg.mode, taps_of(6));
		cam_u.frame_end();
		expect_idle(40, seen);
		`CHECK("no_line", 1'b0, seen)
		$display("end of refusal test");
	endtask
	task automatic test_overflow();
		logic seen;
		set_cfg('{ten_tap_8bit, depth_8, gray_byte, 1'b0});
		send_frame(8, FIFO_DEPTH + 1);
		`CHECK("overflow", 1'b1, overflow)
		collect(8, FIFO_DEPTH);
		expect_idle(40, seen);
		`CHECK("drained", 1'b0, seen)
		$display("end of overflow test");
	endtask

	initial begin
		#900us;
		n_fail++;
		print_verdict();
	end
	initial begin
		cases = '{'{ten_tap_8bit, depth_8, gray_byte, 1'b1}, '{ten_tap_8bit, depth_8, gray_halfword, 1'b1},
			'{ten_tap_8bit, depth_8, color_byte_per_channel, 1'b1},
			'{eight_tap_10bit, depth_10, gray_byte, 1'b1}, '{eight_tap_10bit, depth_10, gray_halfword, 1'b1},
			'{eight_tap_10bit, depth_10, color_byte_per_channel, 1'b1},
			'{eight_tap_10bit, depth_10, color_ten_bit_per_channel, 1'b1},
			'{eight_tap_10bit, depth_10, color_halfword_per_channel, 1'b1},
			'{eight_tap_10bit, depth_12, gray_byte, 1'b1},
			'{eight_tap_10bit, depth_12, color_ten_bit_per_channel, 1'b1},
			'{eight_tap_10bit, depth_12, color_halfword_per_channel, 1'b1}};
		n_fail = 0;
		n_compared = 0;
		rst_i = 1'b1;
		cfg = CONFIG_RESET;
		table_write = 1'b0;
		table_addr = '0;
		table_data = '0;
		out_ready = 1'b0;
		repeat (5) @(posedge clock_i);
		rst_i <= 1'b0;
		@(posedge clock_i);
		test_reset();
		test_bypass();
		test_table();
		test_illegal();
		test_overflow();
		print_verdict();
	end
endmodule // tap_unpack_output_lut_bench
`default_nettype wire

//--- logic/output_table.sv
// Output look-up table with format masking and bypass packing
`default_nettype none
module output_table
	import tap_pkg::*;
#(
	parameter int ADDR_BITS = LUT_IN_BITS,
	parameter int DATA_BITS = PIX_BITS
) (
	input  wire logic                 clock_i,
	input  wire logic                 write_i,
	input  wire logic [ADDR_BITS-1:0] write_addr_i,
	input  wire logic [DATA_BITS-1:0] write_data_i,
	input  wire config_type           cfg_i,
	input  wire sample_type           sample_i,
	output result_type                result_o,
	output logic                      legal_o
);
	if (ADDR_BITS < TAP_BITS || DATA_BITS != PIX_BITS) begin : g_bad
		$error("output_table: table too narrow for the taps");
	end

	logic [DATA_BITS-1:0] table_mem [2**ADDR_BITS];
	int                   in_bits;
	int                   out_bits;
	logic [DATA_BITS-1:0] in_mask;
	logic [DATA_BITS-1:0] out_mask;

	always_ff @(posedge clock_i) begin
		if (write_i) begin
			table_mem[write_addr_i] <= write_data_i;
		end
	end

	always_comb begin
		unique case (cfg_i.depth)
			depth_8: in_bits = DEPTH8_BITS;
			depth_10: in_bits = DEPTH10_BITS;
			depth_12: in_bits = DEPTH12_BITS;
			default: in_bits = DEPTH12_BITS;
		endcase
		// Byte outputs keep 8 bits, halfword keeps the input depth low
		unique case (cfg_i.format)
			gray_byte: out_bits = BYTE_OUT_BITS;
			gray_halfword: out_bits = in_bits;
			color_byte_per_channel: out_bits = BYTE_OUT_BITS;
			color_ten_bit_per_channel: out_bits = TEN_OUT_BITS;
			color_halfword_per_channel: out_bits = in_bits;
			default: out_bits = in_bits;
		endcase
		// Eight-bit colour only maps to one byte per channel
		legal_o = (cfg_i.depth != depth_8) || (cfg_i.format != color_ten_bit_per_channel
			&& cfg_i.format != color_halfword_per_channel);
		if (cfg_i.format > color_halfword_per_channel || cfg_i.depth > depth_12) begin
			legal_o = 1'b0;
		end
		in_mask  = ~({DATA_BITS{1'b1}} << in_bits);
		out_mask = ~({DATA_BITS{1'b1}} << out_bits);
	end

	for (genvar p = 0; p < TAPS_PER_WORD; p++) begin : g_port
		logic [ADDR_BITS-1:0] addr;
		assign addr = ADDR_BITS'(sample_i[p]) & ADDR_BITS'(in_mask);
		// Without a table the sample lands right-aligned, cut to the input depth
		assign result_o[p] = cfg_i.lut_on ? (table_mem[addr] & out_mask)
			: (DATA_BITS'(addr));
	end
endmodule // output_table
`default_nettype wire

//--- logic/pixel_fifo.sv
// Small synchronous FIFO with valid and ready on both sides
`default_nettype none
module pixel_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 8
) (
	input  wire logic             clock_i,
	input  wire logic             rst_i,
	input  wire logic             in_valid_i,
	output logic                  in_ready_o,
	input  wire logic [WIDTH-1:0] in_data_i,
	output logic                  out_valid_o,
	input  wire logic             out_ready_i,
	output logic      [WIDTH-1:0] out_data_o
);
	localparam int PTR_BITS = $clog2(DEPTH);

	if (DEPTH < 2 || (1 << PTR_BITS) != DEPTH || WIDTH < 1) begin : g_bad
		$error("pixel_fifo: DEPTH must be a power of two, at least 2");
	end

	logic [WIDTH-1:0]  store [DEPTH];
	logic [PTR_BITS:0] wr_ptr;
	logic [PTR_BITS:0] rd_ptr;
	logic [PTR_BITS:0] next_wr_ptr;
	logic [PTR_BITS:0] next_rd_ptr;
	logic              push;
	logic              pop;

	// Extra pointer bit tells full from empty without a counter
	assign in_ready_o  = (wr_ptr ^ rd_ptr) != {1'b1, {PTR_BITS{1'b0}}};
	assign out_valid_o = wr_ptr != rd_ptr;
	assign out_data_o  = store[rd_ptr[PTR_BITS-1:0]];

	always_comb begin
		push        = in_valid_i && in_ready_o;
		pop         = out_valid_o && out_ready_i;
		next_wr_ptr = wr_ptr + (PTR_BITS+1)'(push);
		next_rd_ptr = rd_ptr + (PTR_BITS+1)'(pop);
	end

	always_ff @(posedge clock_i or posedge rst_i) begin
		if (rst_i) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
		end else begin
			wr_ptr <= next_wr_ptr;
			rd_ptr <= next_rd_ptr;
		end
	end

	always_ff @(posedge clock_i) begin
		if (push) begin
			store[wr_ptr[PTR_BITS-1:0]] <= in_data_i;
		end
	end
endmodule // pixel_fifo
`default_nettype wire

//--- logic/tap_pkg.sv
// Shared constants and types for the tap unpack and output table path
`default_nettype none
package tap_pkg;
	localparam int LANE_COUNT        = 11;
	localparam int LANE_BITS         = 8;
	localparam int TAP_BITS          = 10;
	localparam int MAX_TAPS          = 10;
	localparam int EIGHT_TAP_COUNT   = 8;
	localparam int LANE_I            = 8;
	localparam int LANE_K            = 10;
	localparam int TAPS_PER_LOW_LANE = 4;
	localparam int LUT_IN_BITS       = 12;
	localparam int PIX_BITS          = 16;
	localparam int TAPS_PER_WORD     = 2;
	localparam int SYNC_STAGES       = 3;
	localparam int FIFO_DEPTH        = 8;
	localparam int DEPTH8_BITS       = 8;
	localparam int DEPTH10_BITS      = 10;
	localparam int DEPTH12_BITS      = 12;
	localparam int BYTE_OUT_BITS     = 8;
	localparam int TEN_OUT_BITS      = 10;
	localparam logic [2:0] TEN_TAP_PAIRS   = 3'h5;
	localparam logic [2:0] EIGHT_TAP_PAIRS = 3'h4;

	typedef enum logic [0:0] {ten_tap_8bit, eight_tap_10bit} tap_mode_type;
	typedef enum logic [1:0] {depth_8, depth_10, depth_12} depth_type;
	typedef enum logic [2:0] {
		gray_byte,
		gray_halfword,
		color_byte_per_channel,
		color_ten_bit_per_channel,
		color_halfword_per_channel
	} format_type;

	typedef struct packed {
		tap_mode_type mode;
		depth_type    depth;
		format_type   format;
		logic         lut_on;
	} config_type;

	typedef logic [LANE_COUNT-1:0][LANE_BITS-1:0] lanes_type;
	typedef logic [TAPS_PER_WORD-1:0][TAP_BITS-1:0] sample_type;
	typedef logic [TAPS_PER_WORD-1:0][PIX_BITS-1:0] result_type;

	typedef struct packed {
		logic [2:0]                         pairs;
		logic [MAX_TAPS-1:0][TAP_BITS-1:0] tap;
	} group_type;

	typedef struct packed {
		logic [PIX_BITS-1:0] second;
		logic [PIX_BITS-1:0] first;
	} word_type;

	localparam config_type CONFIG_RESET = '{ten_tap_8bit, depth_8, gray_byte, 1'b0};
endpackage
`default_nettype wire

//--- logic/tap_unpack_output_lut.sv
// Camera lane unpacker for the two non-standard tap layouts with output table
//
// Contract
// - 8-bit mono: 8-out and 16-out low tables
// - 10-bit mono: 8-out and 16-out low tables
// - 12-bit mono: 8-bit MSB and 16-out tables
// - 10-bit colour maps to 8 or 10 bits
// - 12-bit colour maps to 8, 10, 12 bits
// - No table: bits pass right-aligned, unchanged; the code cuts them to the input depth
// - Only listed depth and format pairs allowed; the code also accepts unlisted 8-bit colour at one byte per channel
// - Ten taps: lane A..J is tap 0..9
// - Tap layout is a separate held configuration
// - Eight taps: lane bits are tap bits 2-9
// - Low bit pairs come on lanes I and K
// - Output table serves both tap layouts
// - Line, frame valid and pixel clock standard
`default_nettype none
module tap_unpack_output_lut
	import tap_pkg::*;
#(
	parameter int BUFFER_DEPTH = FIFO_DEPTH
) (
	input  wire logic                   clock_i,
	input  wire logic                   rst_i,
	input  wire lanes_type              lane_i,
	input  wire logic                   line_valid_i,
	input  wire logic                   frame_valid_i,
	input  wire logic                   pixel_clock_i,
	input  wire tap_mode_type           tap_mode_i,
	input  wire depth_type              depth_i,
	input  wire format_type             format_i,
	input  wire logic                   lut_enable_i,
	input  wire logic                   table_write_i,
	input  wire logic [LUT_IN_BITS-1:0] table_addr_i,
	input  wire logic [PIX_BITS-1:0]    table_data_i,
	input  wire logic                   out_ready_i,
	output logic                        out_valid_o,
	output word_type                    out_data_o,
	output logic                        out_last_o,
	output logic                        frame_active_o,
	output logic                        overflow_o,
	output logic                        config_error_o
);
	localparam int PIN_BITS = LANE_COUNT * LANE_BITS + 3;

	if (BUFFER_DEPTH < 2) begin : g_bad
		$error("tap_unpack_output_lut: buffer too shallow");
	end

	logic [SYNC_STAGES-1:0][PIN_BITS-1:0] pin_sync;
	logic [SYNC_STAGES-1:0][PIN_BITS-1:0] next_pin_sync;
	lanes_type  lanes_s;
	logic       pclk_level;
	logic       line_level;
	logic       frame_level;
	logic       next_pclk_level;
	logic       next_line_level;
	logic       next_frame_level;
	logic       pclk_rise;
	config_type cfg;
	config_type next_cfg;
	logic       cfg_legal;
	group_type  unpacked;
	logic       capture;
	logic       fifo_push;
	logic       fifo_ready;
	logic       group_valid;
	group_type  group;
	logic       group_pop;
	logic [2:0] pair_idx;
	logic [2:0] next_pair_idx;
	logic       last_pair;
	logic       advance;
	sample_type sample;
	result_type result;
	logic       next_out_valid;
	word_type   next_out_data;
	logic       next_out_last;
	logic       next_overflow;
	logic       next_config_error;

	// Pins cross from the camera side, three stages each
	always_comb begin
		next_pin_sync[0] = {pixel_clock_i, line_valid_i, frame_valid_i, lane_i};
		next_pin_sync[1] = pin_sync[0];
		next_pin_sync[2] = pin_sync[1];
	end

	assign lanes_s = pin_sync[2][PIN_BITS-4:0];

	always_comb begin
		next_pclk_level  = pclk_level;
		next_line_level  = line_level;
		next_frame_level = frame_level;
		// A level only moves once the last two stages agree
		if (pin_sync[1][PIN_BITS-1] == pin_sync[2][PIN_BITS-1]) begin
			next_pclk_level = pin_sync[2][PIN_BITS-1];
		end
		if (pin_sync[1][PIN_BITS-2] == pin_sync[2][PIN_BITS-2]) begin
			next_line_level = pin_sync[2][PIN_BITS-2];
		end
		if (pin_sync[1][PIN_BITS-3] == pin_sync[2][PIN_BITS-3]) begin
			next_frame_level = pin_sync[2][PIN_BITS-3];
		end
		// Pixel clock and strobe share one pin in both layouts
		pclk_rise = next_pclk_level && !pclk_level;
	end

	always_ff @(posedge clock_i or posedge rst_i) begin
		if (rst_i) begin
			pin_sync    <= '0;
			pclk_level  <= 1'b0;
			line_level  <= 1'b0;
			frame_level <= 1'b0;
		end else begin
			pin_sync    <= next_pin_sync;
			pclk_level  <= next_pclk_level;
			line_level  <= next_line_level;
			frame_level <= next_frame_level;
		end
	end

	// Layout and format change only between frames, never mid-image
	always_comb begin
		next_cfg = cfg;
		if (!next_frame_level) begin
			next_cfg = '{tap_mode_i, depth_i, format_i, lut_enable_i};
		end
		next_config_error = !cfg_legal;
	end

	always_ff @(posedge clock_i or posedge rst_i) begin
		if (rst_i) begin
			cfg            <= CONFIG_RESET;
			config_error_o <= 1'b0;
		end else begin
			cfg            <= next_cfg;
			config_error_o <= next_config_error;
		end
	end

	for (genvar t = 0; t < MAX_TAPS; t++) begin : g_unpack
		if (t < EIGHT_TAP_COUNT) begin : g_both
			localparam int PAIR_LANE = (t < TAPS_PER_LOW_LANE) ? LANE_I : LANE_K;
			localparam int PAIR_BIT  = 2 * (t % TAPS_PER_LOW_LANE);
			assign unpacked.tap[t] = (cfg.mode == ten_tap_8bit)
				? {{(TAP_BITS-LANE_BITS){1'b0}}, lanes_s[t]}
				: {lanes_s[t], lanes_s[PAIR_LANE][PAIR_BIT+1:PAIR_BIT]};
		end else begin : g_ten_only
			assign unpacked.tap[t] = (cfg.mode == ten_tap_8bit)
				? {{(TAP_BITS-LANE_BITS){1'b0}}, lanes_s[t]}
				: '0;
		end
	end

	assign unpacked.pairs = (cfg.mode == ten_tap_8bit) ? TEN_TAP_PAIRS : EIGHT_TAP_PAIRS;

	// A pixel clock edge outside line and frame carries no pixel
	assign capture   = pclk_rise && next_line_level && next_frame_level;
	assign fifo_push = capture && cfg_legal;

	// A full buffer drops the group; the flag stays until reset
	assign next_overflow = overflow_o || (fifo_push && !fifo_ready);

	pixel_fifo #(
		.WIDTH ($bits(group_type)),
		.DEPTH (BUFFER_DEPTH)
	) u_fifo (
		.clock_i     (clock_i),
		.rst_i       (rst_i),
		.in_valid_i  (fifo_push),
		.in_ready_o  (fifo_ready),
		.in_data_i   (unpacked),
		.out_valid_o (group_valid),
		.out_ready_i (group_pop),
		.out_data_o  (group)
	);

	// Two taps per cycle keeps ten taps inside one pixel clock period
	assign sample[0] = group.tap[{pair_idx, 1'b0}];
	assign sample[1] = group.tap[{pair_idx, 1'b1}];

	// One table for both layouts, fed after unpacking
	output_table #(
		.ADDR_BITS (LUT_IN_BITS),
		.DATA_BITS (PIX_BITS)
	) u_table (
		.clock_i      (clock_i),
		.write_i      (table_write_i),
		.write_addr_i (table_addr_i),
		.write_data_i (table_data_i),
		.cfg_i        (cfg),
		.sample_i     (sample),
		.result_o     (result),
		.legal_o      (cfg_legal)
	);

	always_comb begin
		advance        = group_valid && (!out_valid_o || out_ready_i);
		last_pair      = pair_idx == group.pairs - 3'h1;
		group_pop      = advance && last_pair;
		next_pair_idx  = pair_idx;
		next_out_valid = out_valid_o && !out_ready_i;
		next_out_data  = out_data_o;
		next_out_last  = out_last_o;
		if (advance) begin
			next_pair_idx  = last_pair ? 3'h0 : pair_idx + 3'h1;
			next_out_valid = 1'b1;
			next_out_data  = '{result[1], result[0]};
			next_out_last  = last_pair;
		end
	end

	always_ff @(posedge clock_i or posedge rst_i) begin
		if (rst_i) begin
			pair_idx       <= 3'h0;
			out_valid_o    <= 1'b0;
			out_data_o     <= '0;
			out_last_o     <= 1'b0;
			overflow_o     <= 1'b0;
			frame_active_o <= 1'b0;
		end else begin
			pair_idx       <= next_pair_idx;
			out_valid_o    <= next_out_valid;
			out_data_o     <= next_out_data;
			out_last_o     <= next_out_last;
			overflow_o     <= next_overflow;
			frame_active_o <= next_frame_level;
		end
	end

	chk_capture_gate: assert property (
		@(posedge clock_i) disable iff (rst_i)
		fifo_push |=> line_level && frame_level && pclk_level
	) else $error("pixel taken outside line or frame");

	chk_ten_tap_lanes: assert property (
		@(posedge clock_i) disable iff (rst_i)
		fifo_push && cfg.mode == ten_tap_8bit |->
			unpacked.tap[0][7:0] == lanes_s[0] && unpacked.tap[9][7:0] == lanes_s[9]
			&& unpacked.tap[9][9:8] == 2'h0 && unpacked.pairs == 3'h5
	) else $error("ten-tap lane map wrong");

	chk_high_bits_map: assert property (
		@(posedge clock_i) disable iff (rst_i)
		fifo_push && cfg.mode == eight_tap_10bit |->
			unpacked.tap[7][9:2] == lanes_s[7] && unpacked.pairs == 3'h4
	) else $error("eight-tap high bits wrong");

	chk_low_pair_map: assert property (
		@(posedge clock_i) disable iff (rst_i)
		fifo_push && cfg.mode == eight_tap_10bit |->
			unpacked.tap[3][1:0] == lanes_s[8][7:6] && unpacked.tap[5][1:0] == lanes_s[10][3:2]
	) else $error("eight-tap low pairs wrong");

	chk_illegal_blocked: assert property (
		@(posedge clock_i) disable iff (rst_i)
		cfg.depth == depth_8 && cfg.format == color_ten_bit_per_channel |->
			!fifo_push ##1 config_error_o
	) else $error("unlisted format accepted");

	chk_config_frozen: assert property (
		@(posedge clock_i) disable iff (rst_i)
		frame_level && next_frame_level |=> $stable(cfg)
	) else $error("configuration moved inside a frame");

	chk_bypass_align: assert property (
		@(posedge clock_i) disable iff (rst_i)
		advance && !cfg.lut_on && cfg.depth == depth_10 |=>
			out_data_o.first == {6'h00, $past(sample[0])}
	) else $error("bypass pixel not right-aligned");

	// Bypass keeps the full input depth, so only a table result is cut to a byte
	chk_byte_width: assert property (
		@(posedge clock_i) disable iff (rst_i)
		advance && cfg.lut_on && (cfg.format == gray_byte || cfg.format == color_byte_per_channel) |=>
			out_data_o.first[15:8] == 8'h00 && out_data_o.second[15:8] == 8'h00
	) else $error("byte output wider than 8 bits");

	chk_halfword_low: assert property (
		@(posedge clock_i) disable iff (rst_i)
		advance && cfg.lut_on && cfg.depth == depth_12 &&
			(cfg.format == gray_halfword || cfg.format == color_halfword_per_channel) |=>
			out_data_o.first[15:12] == 4'h0 && out_data_o.second[15:12] == 4'h0
	) else $error("halfword result above its depth");

	chk_tap_order: assert property (
		@(posedge clock_i) disable iff (rst_i)
		advance && !last_pair |=> pair_idx == $past(pair_idx) + 3'h1 && !out_last_o
	) else $error("taps out of order");

	chk_last_marks: assert property (
		@(posedge clock_i) disable iff (rst_i)
		advance && last_pair |=> out_last_o && pair_idx == 3'h0
	) else $error("group end not marked");

	chk_output_hold: assert property (
		@(posedge clock_i) disable iff (rst_i)
		out_valid_o && !out_ready_i |=> out_valid_o && $stable(out_data_o)
	) else $error("output dropped while stalled");
endmodule // tap_unpack_output_lut
`default_nettype wire
